// *** design/asram_ctrl.sv ***
// Notes on behaviour
// - Read data within 70/55 ns of select or address; reads spaced that far.
// - Select held 50/40 ns before write end; strobe pulse at least 40 ns.
// - Write address stable 50/40 ns before write end; may change after.
// - Byte selects asserted 50/40 ns before write end.
// - Write data valid 40/35 ns before write end; removable right after.
// - Page reads keep bits 4..15 fixed and step bits 0..3.
`timescale 1ns/1ns
`include "asram_map.svh"

module asram_ctrl #(
    parameter int T_READ_CYCLE_NS = `ASRAM_T_READ_CYCLE_NS,
    parameter int T_ADDR_TO_DATA_NS = `ASRAM_T_ADDR_TO_DATA_NS,
    parameter int T_SEL_TO_WEND_NS = `ASRAM_T_SELECT_TO_WRITE_END_NS,
    parameter int T_WPULSE_NS = `ASRAM_T_WRITE_PULSE_NS,
    parameter int T_WDATA_NS = `ASRAM_T_WRITE_DATA_SETUP_NS,
    parameter int T_WEND_DRIVE_NS = `ASRAM_T_WRITE_END_TO_DRIVE_NS,
    parameter int T_FLOAT_NS = `ASRAM_T_DRIVE_TO_FLOAT_NS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // User request
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`ASRAM_ADDR_W-1:0] req_addr_i,
    input wire logic [`ASRAM_DATA_W-1:0] req_wdata_i,
    input wire logic [1:0] req_bytes_i,
    output logic req_ready_o,
    // User read answer
    output logic rsp_valid_o,
    output logic [`ASRAM_DATA_W-1:0] rsp_rdata_o,
    // Memory pins
    output logic [`ASRAM_ADDR_W-1:0] mem_addr_o,
    output logic select_low_active_o,
    output logic select_high_active_o,
    output logic write_strobe_n_o,
    output logic output_drive_n_o,
    output logic upper_byte_sel_n_o,
    output logic lower_byte_sel_n_o,
    output logic [`ASRAM_DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    input wire logic [`ASRAM_DATA_W-1:0] mem_data_i
);
    import asram_pkg::*;

    function automatic logic [7:0] cyc(input int ns);
        cyc = 8'(`ASRAM_CYC(ns));
    endfunction : cyc

    function automatic logic [7:0] max2(input logic [7:0] a, input logic [7:0] b);
        max2 = (a > b) ? a : b;
    endfunction : max2

    // Read wait covers cycle time, access time and the two synchroniser stages
    localparam logic [7:0] RD_CYC = max2(cyc(T_READ_CYCLE_NS), cyc(T_ADDR_TO_DATA_NS)) + 8'h02;
    localparam logic [7:0] WSET_CYC = cyc(T_FLOAT_NS);
    localparam logic [7:0] WP_CYC = max2(max2(cyc(T_WPULSE_NS), cyc(T_WDATA_NS)),
                                         cyc(T_SEL_TO_WEND_NS));
    localparam logic [7:0] WREC_CYC = cyc(T_WEND_DRIVE_NS);

    ////////////////////////////////////////////////////////////////////////////
    asram_state_t state_q;
    logic [7:0] cnt_q;
    logic [`ASRAM_DATA_W-1:0] sync1_q;
    logic [`ASRAM_DATA_W-1:0] sync2_q;

    // Read data pins are asynchronous to our clock
    always_ff @(posedge clock_i) begin
        sync1_q <= mem_data_i;
        sync2_q <= sync1_q;
    end

    wire logic take = req_valid_i && req_ready_o;
    wire logic cnt_done = (cnt_q == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state_q <= ASRAM_IDLE;
            cnt_q <= 8'h00;
        end else begin
            case (state_q)
                ASRAM_IDLE: begin
                    if (take && req_write_i) begin
                        state_q <= ASRAM_WSET;
                        cnt_q <= WSET_CYC - 8'h01;
                    end else if (take) begin
                        state_q <= ASRAM_READ;
                        cnt_q <= RD_CYC - 8'h01;
                    end
                end
                ASRAM_READ: begin
                    if (cnt_done) begin
                        state_q <= ASRAM_RFLOAT;
                        cnt_q <= cyc(T_FLOAT_NS) - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ASRAM_RFLOAT: begin
                    // Keep our driver off until the memory has let go of the bus
                    if (cnt_done) begin
                        state_q <= ASRAM_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ASRAM_WSET: begin
                    if (cnt_done) begin
                        state_q <= ASRAM_WPULSE;
                        cnt_q <= WP_CYC - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ASRAM_WPULSE: begin
                    if (cnt_done) begin
                        state_q <= ASRAM_WREC;
                        cnt_q <= WREC_CYC - 8'h01;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ASRAM_WREC: begin
                    if (cnt_done) begin
                        state_q <= ASRAM_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= ASRAM_IDLE;
                    cnt_q <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: address, bytes and data are latched at accept; bytes are released in idle, address and data hold to the next accept
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            mem_addr_o <= 16'h0000;
            mem_data_o <= 16'h0000;
            upper_byte_sel_n_o <= 1'b1;
            lower_byte_sel_n_o <= 1'b1;
        end else if (take) begin
            mem_addr_o <= req_addr_i;
            mem_data_o <= req_wdata_i;
            lower_byte_sel_n_o <= ~req_bytes_i[0];
            upper_byte_sel_n_o <= ~req_bytes_i[1];
        end else if (state_q == ASRAM_IDLE) begin
            upper_byte_sel_n_o <= 1'b1;
            lower_byte_sel_n_o <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            select_low_active_o <= 1'b1;
            select_high_active_o <= 1'b0;
        end else begin
            // Standby between accesses saves power
            select_low_active_o <= !(take || (state_q != ASRAM_IDLE));
            select_high_active_o <= take || (state_q != ASRAM_IDLE);
        end
    end

    wire logic enter_wp = (state_q == ASRAM_WSET) && cnt_done;
    wire logic stay_wp = (state_q == ASRAM_WPULSE) && !cnt_done;
    wire logic enter_rd = take && !req_write_i;
    wire logic stay_rd = (state_q == ASRAM_READ) && !cnt_done;

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            write_strobe_n_o <= 1'b1;
            output_drive_n_o <= 1'b1;
            mem_data_oe_o <= 1'b0;
        end else begin
            write_strobe_n_o <= !(enter_wp || stay_wp);
            output_drive_n_o <= !(enter_rd || stay_rd);
            // Drive data only in write states; output drive is already high there
            mem_data_oe_o <= enter_wp || stay_wp ||
                             ((state_q == ASRAM_WSET) && (cnt_q == 8'h00));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
            req_ready_o <= 1'b0;
        end else begin
            rsp_valid_o <= (state_q == ASRAM_READ) && cnt_done;
            if ((state_q == ASRAM_READ) && cnt_done) begin
                rsp_rdata_o <= sync2_q;
            end
            req_ready_o <= (state_q == ASRAM_IDLE) && !take &&
                           !(state_q == ASRAM_IDLE && req_ready_o && req_valid_i);
            if (((state_q == ASRAM_RFLOAT) || (state_q == ASRAM_WREC)) && cnt_done) begin
                req_ready_o <= 1'b1;
            end
        end
    end
endmodule : asram_ctrl

// *** design/asram_map.svh ***
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH

// Clock period in picoseconds (250 MHz)
`define ASRAM_CLK_PS 4000
// Timing figures in ns, default is the slow grade
`define ASRAM_T_READ_CYCLE_NS 70
`define ASRAM_T_ADDR_TO_DATA_NS 70
`define ASRAM_T_DATA_HOLD_NS 10
`define ASRAM_T_SELECT_TO_WRITE_END_NS 50
`define ASRAM_T_WRITE_PULSE_NS 40
`define ASRAM_T_WRITE_DATA_SETUP_NS 40
`define ASRAM_T_WRITE_TO_FLOAT_NS 20
`define ASRAM_T_WRITE_END_TO_DRIVE_NS 5
`define ASRAM_T_DRIVE_TO_FLOAT_NS 20
// Cycle counts, rounded up
`define ASRAM_CYC(ns) ((((ns) * 1000) + `ASRAM_CLK_PS - 1) / `ASRAM_CLK_PS)
// Page field of the word address
`define ASRAM_PAGE_LSB 4
`define ASRAM_ADDR_W 16
`define ASRAM_DATA_W 16

`endif

// *** design/asram_pkg.sv ***
package asram_pkg;
    typedef enum logic [2:0] {
        ASRAM_IDLE = 3'b000,
        ASRAM_READ = 3'b001,
        ASRAM_WSET = 3'b010,
        ASRAM_WPULSE = 3'b011,
        ASRAM_WREC = 3'b100,
        ASRAM_RFLOAT = 3'b101
    } asram_state_t;
endpackage : asram_pkg

// *** bench/asram_mem_model.sv ***
`timescale 1ns/1ns
module asram_mem_model #(
    parameter int DLY = 0
) (
    // Memory pins
    input wire logic [15:0] addr_i,
    input wire logic sel_n_i,
    input wire logic sel_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic ub_n_i,
    input wire logic lb_n_i,
    input wire logic [15:0] ctl_i,
    input wire logic ctl_oe_i,
    output logic [15:0] bus_o
);
    logic [15:0] mem_q [65536];
    logic act;
    logic rd;
    logic [15:0] q;
    initial foreach (mem_q[i]) mem_q[i] = 16'h0000;
    assign act = !sel_n_i && sel_i && !(ub_n_i && lb_n_i);
    assign rd = act && we_n_i && !oe_n_i;
    assign #(DLY) q = mem_q[addr_i];
    // Idle lanes show the inverse of the driven word, so a stale value never passes
    always_comb begin
        bus_o = ctl_oe_i ? ctl_i : ~ctl_i;
        if (!ctl_oe_i && rd && !lb_n_i) bus_o[7:0] = q[7:0];
        if (!ctl_oe_i && rd && !ub_n_i) bus_o[15:8] = q[15:8];
    end
    always @(posedge we_n_i) begin
        if (act && !lb_n_i) mem_q[addr_i][7:0] = ctl_i[7:0];
        if (act && !ub_n_i) mem_q[addr_i][15:8] = ctl_i[15:8];
    end
endmodule : asram_mem_model

// *** bench/asram_ctrl_chk.sv ***
`timescale 1ns/1ns
module asram_ctrl_chk (
    // Clock, reset and pins
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic rsp_valid_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic select_low_active_o,
    input wire logic select_high_active_o,
    input wire logic write_strobe_n_o,
    input wire logic output_drive_n_o,
    input wire logic upper_byte_sel_n_o,
    input wire logic lower_byte_sel_n_o,
    input wire logic [15:0] mem_data_o,
    input wire logic mem_data_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    a_wpulse_width: assert property ($rose(write_strobe_n_o) |-> !$past(write_strobe_n_o, 10))
        else $error("write pulse short");
    a_sel_wend: assert property ($rose(write_strobe_n_o) |->
        !$past(select_low_active_o, 13) && $past(select_high_active_o, 13))
        else $error("select late for write");
    a_addr_wend: assert property ($rose(write_strobe_n_o) |-> $past(mem_addr_o, 13) == mem_addr_o)
        else $error("write address moved");
    a_bytes_wend: assert property ($rose(write_strobe_n_o) |->
        $past(upper_byte_sel_n_o, 13) == upper_byte_sel_n_o &&
        $past(lower_byte_sel_n_o, 13) == lower_byte_sel_n_o)
        else $error("byte selects late");
    a_data_wend: assert property ($rose(write_strobe_n_o) |->
        $past(mem_data_oe_o, 10) && $past(mem_data_o, 10) == mem_data_o)
        else $error("write data late");
    a_read_space: assert property (rsp_valid_o |-> $past(mem_addr_o, 16) == mem_addr_o)
        else $error("read address too short");
    a_no_clash: assert property (mem_data_oe_o |-> output_drive_n_o)
        else $error("bus driven by both");
    a_float_gap: assert property ($rose(mem_data_oe_o) |-> $past(output_drive_n_o, 5))
        else $error("no float gap");
    a_drive_sel: assert property (!output_drive_n_o |->
        !select_low_active_o && select_high_active_o)
        else $error("drive while deselected");
endmodule : asram_ctrl_chk
bind asram_ctrl asram_ctrl_chk asram_ctrl_chk_inst (.*);

// *** bench/asram_ctrl_tb_top.sv ***
`timescale 1ns/1ns
module asram_ctrl_tb_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [15:0] req_wdata_i = 16'h0000;
    logic [1:0] req_bytes_i = 2'b00;
    logic req_ready_o, rsp_valid_o, select_low_active_o, select_high_active_o;
    logic write_strobe_n_o, output_drive_n_o, upper_byte_sel_n_o, lower_byte_sel_n_o;
    logic mem_data_oe_o;
    logic [15:0] rsp_rdata_o, mem_addr_o, mem_data_o, mem_data_i;
    logic [15:0] shadow [65536];
    logic [31:0] seed = 32'h0000_41c5;
    logic [31:0] r;
    int bad_count = 0;
    int compares = 0;
    always #2 clock_i = ~clock_i;
    asram_ctrl asram_ctrl_inst (.*);
    // Slow answer: data settles well after the address, inside the read wait
    asram_mem_model #(.DLY(50)) asram_mem_model_inst (.addr_i(mem_addr_o),
        .sel_n_i(select_low_active_o), .sel_i(select_high_active_o),
        .we_n_i(write_strobe_n_o), .oe_n_i(output_drive_n_o), .ub_n_i(upper_byte_sel_n_o),
        .lb_n_i(lower_byte_sel_n_o), .ctl_i(mem_data_o), .ctl_oe_i(mem_data_oe_o),
        .bus_o(mem_data_i));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] lanes(input logic [1:0] b);
        return {{8{b[1]}}, {8{b[0]}}};
    endfunction : lanes
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Select instead of a reference argument, so every simulator takes the wait
    task automatic wait_hi(input bit rsp);
        int i;
        i = 0;
        while ((rsp ? rsp_valid_o : req_ready_o) !== 1'b1) begin
            i++;
            if (i > 200) begin
                bad_count++;
                stop_test();
            end
            @(negedge clock_i);
        end
    endtask : wait_hi
    task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d,
            input logic [1:0] b);
        @(negedge clock_i);
        wait_hi(1'b0);
        {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_bytes_i} = {1'b1, w, a, d, b};
        @(negedge clock_i);
        req_valid_i = 1'b0;
        if (w) shadow[a] = (shadow[a] & ~lanes(b)) | (d & lanes(b));
        else begin
            wait_hi(1'b1);
            chk("rdata", rsp_rdata_o & lanes(b), shadow[a] & lanes(b));
        end
    endtask : op
    initial begin
        foreach (shadow[i]) shadow[i] = 16'h0000;
        repeat (16) @(negedge clock_i);
        nrst_i = 1'b1;
        op(1, 16'h0000, 16'ha5c3, 2'b11);
        op(1, 16'hffff, 16'h1234, 2'b11);
        op(1, 16'hffff, 16'h00ee, 2'b01);
        op(1, 16'hffff, 16'h7700, 2'b10);
        op(1, 16'h0000, 16'h5a5a, 2'b00);
        op(0, 16'hffff, 16'h0000, 2'b11);
        op(0, 16'h0000, 16'h0000, 2'b11);
        op(0, 16'hffff, 16'h0000, 2'b01);
        op(0, 16'hffff, 16'h0000, 2'b10);
        $display("test lanes done");
        // Reset in mid-run, during the read float wait: pins must fall back to standby
        nrst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk("idle pins", {select_low_active_o, select_high_active_o, write_strobe_n_o,
            output_drive_n_o, req_ready_o, mem_data_oe_o}, 16'h002c);
        nrst_i = 1'b1;
        $display("test reset done");
        for (int k = 0; k < 32; k++) begin
            r = rnd();
            op(k < 16, {12'h3c7, 4'(k)}, r[15:0], 2'b11);
        end
        $display("test page done");
        for (int k = 0; k < 60; k++) begin
            r = rnd();
            op(r[0], {r[20] ? 12'hfff : 12'h012, r[3:0]}, r[31:16],
                (!r[0] && r[5:4] == 2'b00) ? 2'b11 : r[5:4]);
        end
        $display("test random done");
        stop_test();
    end
endmodule : asram_ctrl_tb_top
